// ### rtl/twp_pkg.sv
// Package: register map, field layouts, reset values and shared types
package twp_pkg;

   // ==========================================================
   // Register byte addresses
   localparam logic [7:0] TWP_ADDR_TIMER_COUNT = 8'h00;
   localparam logic [7:0] TWP_ADDR_TIMER_CTRL = 8'h04;
   localparam logic [7:0] TWP_ADDR_WD_CTRL = 8'h08;
   localparam logic [7:0] TWP_ADDR_IRQ_MASK = 8'h0C;
   localparam logic [7:0] TWP_ADDR_PORT5_DATA = 8'h10;
   localparam logic [7:0] TWP_ADDR_PORT5_DIR = 8'h14;
   localparam logic [7:0] TWP_ADDR_STATUS = 8'h18;
   localparam logic [7:0] TWP_ADDR_MISC_CTRL = 8'h1C;
   localparam logic [7:0] TWP_ADDR_WD_COUNT = 8'h20;

   // ==========================================================
   // Reset values
   localparam logic [7:0] TWP_RST_TIMER_CTRL = 8'hBF;
   localparam logic [7:0] TWP_RST_WD_CTRL = 8'h80;
   localparam logic [7:0] TWP_RST_IRQ_MASK = 8'h00;
   localparam logic [7:0] TWP_RST_TIMER_COUNT = 8'h00;
   localparam logic TWP_RST_PORT5_DIR = 1'b1;

   // ==========================================================
   // Field positions of the status, misc and interrupt mask registers
   localparam int TWP_STAT_OVF_BIT = 0;
   localparam int TWP_STAT_SLEEP_BIT = 1;
   localparam int TWP_MISC_CONV_WAKE_BIT = 0;
   localparam int TWP_IRQ_MASK_TIMER_BIT = 0;

   // ==========================================================
   // Register layouts, msb first
   typedef struct packed {
      logic watchdog_enable_bit;
      logic ext_irq_pin_select;
      logic wd_prescale_enable;
      logic [2:0] wd_prescale_ratio;
      logic [1:0] unused;
   } twp_wd_ctrl_t;

   typedef struct packed {
      logic timer_prescale_enable;
      logic reserved;
      logic timer_source_ext;
      logic timer_edge_falling;
      logic timer_prescale_assign;
      logic [2:0] timer_prescale_ratio;
   } twp_timer_ctrl_t;

   // AHB-Lite address phase as captured by the slave
   typedef struct packed {
      logic [7:0] addr;
      logic write;
   } twp_ahb_cmd_t;

endpackage

// ### rtl/twp_prescaler.sv
// Eight-bit ratio prescaler: divides an input tick by 2 to 256 or passes it
module twp_prescaler
   import twp_pkg::*;
#(
   parameter int PS_W = 8
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Control
   input wire logic clear,
   input wire logic bypass,
   input wire logic [2:0] ratio,
   // Ticks
   input wire logic tick_in,
   output logic tick_out
);

   // ==========================================================
   // Parameter check
   if (PS_W < 8) begin : g_chk
      $error("twp_prescaler: PS_W must be at least 8");
   end

   logic [PS_W-1:0] count_r;
   logic [PS_W:0] span;
   logic [PS_W-1:0] mask;
   logic [3:0] shift;

   // ==========================================================
   // Ratio decode: code n divides by 2^(n+1)
   always_comb begin
      shift = {1'b0, ratio} + 4'h1;
      span = (PS_W+1)'(1) << shift;
      mask = PS_W'(span - (PS_W+1)'(1));
   end

   assign tick_out = tick_in & (bypass | ((count_r & mask) == mask));

   always_ff @(posedge sys_clk) begin
      if (reset || clear) begin
         count_r <= '0;
      end else if (tick_in) begin
         count_r <= count_r + PS_W'(1);
      end
   end

endmodule

// ### rtl/twp_timer_watchdog.sv
// Timer/counter and watchdog with their prescalers, reached over AHB-Lite
//
// How it works
// - Watchdog control bit 7 enables the watchdog; software reads and writes it.
// - Prescale enable bit 5 low gives watchdog ratio 1:1, high uses ratio field.
// - Ratio field bits 4..2: code 0 divides by 2, each step doubles, to 256.
// - Watchdog control bits 1 and 0 always read zero.
// - Bit 6 makes port 5 bit 0 plain I/O or active-low external interrupt.
// - Interrupt select low masks the interrupt path; high shows pin in port data.
// - Two separate 8-bit prescaler counters, one for timer, one for watchdog.
// - Timer ratio from timer control field; watchdog ratio from watchdog control.
// - Each write to the timer count clears the timer prescaler.
// - Watchdog-clear or sleep instruction clears watchdog counter and its prescaler.
// - Timer is 8-bit, clocked internally or by selectable edge of input pin.
// - Internal source increments the timer every clock, bypassing the prescaler.
// - External source increments the timer on selected pin edges, passed through the timer prescaler.
// - Internal timer stops in sleep unless converting with conversion wake set.
// - Watchdog runs from its own oscillator and keeps counting in sleep.
// - Enabled watchdog time-out resets the device, awake or asleep.
// - Software may enable or disable the watchdog at any time.
// - Interrupt mask bit 0 gates the timer overflow flag onto its interrupt.
// - Any reset sets watchdog control bit 7 and clears bits 6..0.
//
// The register offsets and the AHB-Lite register port were decided locally.
module twp_timer_watchdog
   import twp_pkg::*;
#(
   parameter int WD_CNT_W = 8,
   parameter int PS_W = 8
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Core instruction strobes
   input wire logic wd_clear_instruction,
   input wire logic sleep_instruction,
   input wire logic wake_event,
   input wire logic conversion_busy,
   // Pins
   input wire logic wd_osc_pin,
   input wire logic timer_in_pin,
   input wire logic port5_bit0_pin_in,
   output logic port5_bit0_pin_out,
   output logic port5_bit0_pin_oe_n,
   // Events to the core
   output logic wd_reset_req,
   output logic ext_irq_req,
   output logic timer_irq
);

   // ==========================================================
   // Parameter checks
   if (WD_CNT_W < 1 || WD_CNT_W > 16) begin : g_chk_wd
      $error("twp_timer_watchdog: WD_CNT_W must be 1..16");
   end
   if (PS_W < 8) begin : g_chk_ps
      $error("twp_timer_watchdog: PS_W must be at least 8");
   end

   // ==========================================================
   // Declarations
   twp_ahb_cmd_t cmd_r;
   logic cmd_valid_r;
   logic rd_wait_r;
   logic [31:0] hrdata_r;
   logic [31:0] rd_mux;
   logic wr_en;
   logic [7:0] wdata;

   twp_wd_ctrl_t wd_ctrl_r;
   twp_timer_ctrl_t timer_ctrl_r;
   logic [7:0] irq_mask_r;
   logic [7:0] timer_count_r;
   logic timer_ovf_r;
   logic asleep_r;
   logic conv_wake_en_r;
   logic port5_out_r;
   logic port5_dir_r;
   logic [WD_CNT_W-1:0] wd_count_r;
   logic wd_reset_req_r;

   logic wd_osc_s1_r, wd_osc_s2_r, wd_osc_d_r;
   logic tin_s1_r, tin_s2_r, tin_d_r;
   logic p50_s1_r, p50_s2_r;

   logic wd_base_tick;
   logic wd_tick;
   logic wd_clear;
   logic wd_timeout;
   logic tin_edge;
   logic timer_ps_tick;
   logic timer_inc;
   logic timer_run_int;
   logic timer_write;
   logic timer_ps_clear;

   // ==========================================================
   // Pin synchronisers
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         wd_osc_s1_r <= 1'b0;
         wd_osc_s2_r <= 1'b0;
         wd_osc_d_r <= 1'b0;
      end else begin
         wd_osc_s1_r <= wd_osc_pin;
         wd_osc_s2_r <= wd_osc_s1_r;
         wd_osc_d_r <= wd_osc_s2_r;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         tin_s1_r <= 1'b0;
         tin_s2_r <= 1'b0;
         tin_d_r <= 1'b0;
      end else begin
         tin_s1_r <= timer_in_pin;
         tin_s2_r <= tin_s1_r;
         tin_d_r <= tin_s2_r;
      end
   end

   // Pin idles high through the pull-up, so start high
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         p50_s1_r <= 1'b1;
         p50_s2_r <= 1'b1;
      end else begin
         p50_s1_r <= port5_bit0_pin_in;
         p50_s2_r <= p50_s1_r;
      end
   end

   // ==========================================================
   // AHB-Lite slave
   // Reads take one wait state so a write in the previous data phase is seen
   assign hresp = 1'b0;
   assign hreadyout = ~rd_wait_r;
   assign hrdata = hrdata_r;
   assign wr_en = cmd_valid_r & cmd_r.write;
   assign wdata = hwdata[7:0];

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cmd_valid_r <= 1'b0;
         cmd_r <= '0;
      end else if (hready) begin
         cmd_valid_r <= hsel & htrans[1];
         cmd_r.addr <= {haddr[7:2], 2'b00};
         cmd_r.write <= hwrite;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rd_wait_r <= 1'b0;
      end else if (rd_wait_r) begin
         rd_wait_r <= 1'b0;
      end else if (hready) begin
         rd_wait_r <= hsel & htrans[1] & ~hwrite;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         hrdata_r <= '0;
      end else if (rd_wait_r) begin
         hrdata_r <= rd_mux;
      end
   end

   // Unmapped addresses read as zero and ignore writes
   always_comb begin
      rd_mux = '0;
      case (cmd_r.addr)
         TWP_ADDR_TIMER_COUNT: rd_mux[7:0] = timer_count_r;
         TWP_ADDR_TIMER_CTRL: rd_mux[7:0] = {timer_ctrl_r[7], 1'b0, timer_ctrl_r[5:0]};
         TWP_ADDR_WD_CTRL: rd_mux[7:0] = {wd_ctrl_r[7:2], 2'b00};
         TWP_ADDR_IRQ_MASK: rd_mux[7:0] = irq_mask_r;
         // Pin level shows when input or when used as interrupt
         TWP_ADDR_PORT5_DATA: rd_mux[0] = (port5_dir_r | wd_ctrl_r.ext_irq_pin_select) ?
            p50_s2_r : port5_out_r;
         TWP_ADDR_PORT5_DIR: rd_mux[0] = port5_dir_r;
         TWP_ADDR_STATUS: begin
            rd_mux[TWP_STAT_OVF_BIT] = timer_ovf_r;
            rd_mux[TWP_STAT_SLEEP_BIT] = asleep_r;
         end
         TWP_ADDR_MISC_CTRL: rd_mux[TWP_MISC_CONV_WAKE_BIT] = conv_wake_en_r;
         TWP_ADDR_WD_COUNT: rd_mux[WD_CNT_W-1:0] = wd_count_r;
         default: rd_mux = '0;
      endcase
   end

   // ==========================================================
   // Control registers
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         wd_ctrl_r <= TWP_RST_WD_CTRL;
      end else if (wr_en && cmd_r.addr == TWP_ADDR_WD_CTRL) begin
         wd_ctrl_r <= {wdata[7:2], 2'b00};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         timer_ctrl_r <= TWP_RST_TIMER_CTRL;
      end else if (wr_en && cmd_r.addr == TWP_ADDR_TIMER_CTRL) begin
         timer_ctrl_r <= wdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         irq_mask_r <= TWP_RST_IRQ_MASK;
      end else if (wr_en && cmd_r.addr == TWP_ADDR_IRQ_MASK) begin
         irq_mask_r <= wdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         conv_wake_en_r <= 1'b0;
      end else if (wr_en && cmd_r.addr == TWP_ADDR_MISC_CTRL) begin
         conv_wake_en_r <= wdata[TWP_MISC_CONV_WAKE_BIT];
      end
   end

   // ==========================================================
   // Port 5 bit 0: plain I/O or external interrupt input
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         port5_out_r <= 1'b0;
         port5_dir_r <= TWP_RST_PORT5_DIR;
      end else if (wr_en) begin
         if (cmd_r.addr == TWP_ADDR_PORT5_DATA) begin
            port5_out_r <= wdata[0];
         end
         if (cmd_r.addr == TWP_ADDR_PORT5_DIR) begin
            port5_dir_r <= wdata[0];
         end
      end
   end

   // Interrupt role never drives the pin, even if software forgot the direction
   assign port5_bit0_pin_out = port5_out_r;
   assign port5_bit0_pin_oe_n = port5_dir_r | wd_ctrl_r.ext_irq_pin_select;
   assign ext_irq_req = wd_ctrl_r.ext_irq_pin_select & ~p50_s2_r;

   // ==========================================================
   // Sleep state
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         asleep_r <= 1'b0;
      end else if (sleep_instruction) begin
         asleep_r <= 1'b1;
      end else if (wake_event || wd_timeout) begin
         asleep_r <= 1'b0;
      end
   end

   // ==========================================================
   // General timer
   assign tin_edge = timer_ctrl_r.timer_edge_falling ? (tin_d_r & ~tin_s2_r)
                                                    : (~tin_d_r & tin_s2_r);
   assign timer_run_int = ~asleep_r | (conv_wake_en_r & conversion_busy);
   assign timer_write = wr_en && cmd_r.addr == TWP_ADDR_TIMER_COUNT;
   assign timer_ps_clear = timer_write;

   twp_prescaler #(
      .PS_W(PS_W)
   ) u_timer_ps (
      .sys_clk(sys_clk),
      .reset(reset),
      .clear(timer_ps_clear),
      .bypass(~timer_ctrl_r.timer_prescale_enable),
      .ratio(timer_ctrl_r.timer_prescale_ratio),
      .tick_in(tin_edge),
      .tick_out(timer_ps_tick)
   );

   // Internal source bypasses the prescaler
   assign timer_inc = timer_ctrl_r.timer_source_ext ? timer_ps_tick : timer_run_int;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         timer_count_r <= TWP_RST_TIMER_COUNT;
      end else if (timer_write) begin
         timer_count_r <= wdata;
      end else if (timer_inc) begin
         timer_count_r <= timer_count_r + 8'h01;
      end
   end

   // Overflow flag: write 1 clears, a new overflow in that cycle wins
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         timer_ovf_r <= 1'b0;
      end else if (timer_inc && !timer_write && timer_count_r == 8'hFF) begin
         timer_ovf_r <= 1'b1;
      end else if (wr_en && cmd_r.addr == TWP_ADDR_STATUS && wdata[TWP_STAT_OVF_BIT]) begin
         timer_ovf_r <= 1'b0;
      end
   end

   assign timer_irq = timer_ovf_r & irq_mask_r[TWP_IRQ_MASK_TIMER_BIT];

   // ==========================================================
   // Watchdog
   // Base tick is the own oscillator, independent of sleep
   assign wd_base_tick = wd_osc_s2_r & ~wd_osc_d_r & wd_ctrl_r.watchdog_enable_bit;
   assign wd_clear = wd_clear_instruction | sleep_instruction;

   twp_prescaler #(
      .PS_W(PS_W)
   ) u_wd_ps (
      .sys_clk(sys_clk),
      .reset(reset),
      .clear(wd_clear),
      .bypass(~wd_ctrl_r.wd_prescale_enable),
      .ratio(wd_ctrl_r.wd_prescale_ratio),
      .tick_in(wd_base_tick),
      .tick_out(wd_tick)
   );

   assign wd_timeout = wd_tick & ~wd_clear & (&wd_count_r);

   // Disabled watchdog is held at zero so re-enabling at ratio 1:1 starts a full period
   always_ff @(posedge sys_clk) begin
      if (reset || wd_clear || !wd_ctrl_r.watchdog_enable_bit) begin
         wd_count_r <= '0;
      end else if (wd_tick) begin
         wd_count_r <= wd_count_r + WD_CNT_W'(1);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         wd_reset_req_r <= 1'b0;
      end else begin
         wd_reset_req_r <= wd_timeout;
      end
   end

   assign wd_reset_req = wd_reset_req_r;

endmodule

// ### verif/test_twp_timer_watchdog.sv
// Self-checking bench of the timer, watchdog and port 5 pin block
module test_twp_timer_watchdog
   import twp_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // Short watchdog count keeps the ratio sweep brief
   localparam int WDW = 2;
   logic sys_clk, reset, hsel, hwrite, hreadyout, hresp, rd_pend;
   logic wd_clear_instruction, sleep_instruction, wake_event, conversion_busy;
   logic wd_osc_pin, timer_in_pin, port5_bit0_pin_in, port5_bit0_pin_out, port5_bit0_pin_oe_n;
   logic wd_reset_req, ext_irq_req, timer_irq;
   logic [31:0] haddr, hwdata, hrdata, lf;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [32:0] note_q[$];
   logic [7:0] tc[4] = '{8'h20, 8'h30, 8'hA0, 8'hA1};
   int pre[4] = '{0, 0, 0, 3};
   int post[4] = '{5, 5, 6, 3};
   int ex[4] = '{4, 5, 3, 0};
   int failures, check_count, wd_pulses;

   twp_timer_watchdog #(.WD_CNT_W(WDW), .PS_W(8)) u_twp_timer_watchdog (
      .sys_clk(sys_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .wd_clear_instruction(wd_clear_instruction), .sleep_instruction(sleep_instruction),
      .wake_event(wake_event), .conversion_busy(conversion_busy), .wd_osc_pin(wd_osc_pin),
      .timer_in_pin(timer_in_pin), .port5_bit0_pin_in(port5_bit0_pin_in),
      .port5_bit0_pin_out(port5_bit0_pin_out), .port5_bit0_pin_oe_n(port5_bit0_pin_oe_n),
      .wd_reset_req(wd_reset_req), .ext_irq_req(ext_irq_req), .timer_irq(timer_irq));

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic test_done;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // ==========================================================
   // Bus master: reads leave a note for the monitor
   task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d, input logic c,
                      input logic [7:0] e, output logic [7:0] v);
      @(posedge sys_clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= w;
      if (!w)
         note_q.push_back({c, 24'h0, e});
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      v = hrdata[7:0];
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] v;
      bus(a, 1'b1, d, 1'b0, 8'h00, v);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] v;
      bus(a, 1'b0, 8'h00, 1'b1, e, v);
   endtask

   task automatic rdv(input logic [7:0] a, output logic [7:0] v);
      bus(a, 1'b0, 8'h00, 1'b0, 8'h00, v);
   endtask

   task automatic pulse(input logic [2:0] k);
      @(posedge sys_clk);
      {wake_event, sleep_instruction, wd_clear_instruction} <= k;
      @(posedge sys_clk);
      {wake_event, sleep_instruction, wd_clear_instruction} <= 3'b000;
   endtask

   task automatic osc(input int n);
      repeat (n) begin
         @(posedge sys_clk);
         wd_osc_pin <= 1'b1;
         repeat (3) @(posedge sys_clk);
         wd_osc_pin <= 1'b0;
         repeat (4) @(posedge sys_clk);
      end
   endtask

   // Levels last four clocks, well above the minimum
   task automatic tpin(input int n);
      repeat (n) begin
         repeat (4) @(posedge sys_clk);
         timer_in_pin <= 1'b1;
         repeat (4) @(posedge sys_clk);
         timer_in_pin <= 1'b0;
      end
      repeat (6) @(posedge sys_clk);
   endtask

   // ==========================================================
   // Monitor: read data against the oldest note, watchdog pulses
   always @(posedge sys_clk) begin
      if (rd_pend && hreadyout === 1'b1) begin
         rd_pend <= 1'b0;
         if (note_q[0][32])
            check(hrdata, note_q[0][31:0]);
         void'(note_q.pop_front());
      end
      if (hsel && htrans[1] && !hwrite && hreadyout === 1'b1)
         rd_pend <= 1'b1;
      if (wd_reset_req === 1'b1)
         wd_pulses++;
   end

   initial begin
      #300us;
      failures++;
      test_done;
   end

   initial begin
      logic [7:0] v1, v2;
      int n, p;
      {hsel, hwrite, wd_clear_instruction, sleep_instruction, wake_event, conversion_busy} = 6'h00;
      {wd_osc_pin, timer_in_pin, rd_pend} = 3'h0;
      port5_bit0_pin_in = 1'b1;
      haddr = 32'h0;
      hwdata = 32'h0;
      htrans = 2'b00;
      hsize = 3'b010;
      lf = 32'h2E635F12;
      reset = 1'b1;
      repeat (12) @(posedge sys_clk);
      reset <= 1'b0;
      rd(TWP_ADDR_WD_CTRL, 8'h80);
      rd(TWP_ADDR_IRQ_MASK, 8'h00);
      rd(TWP_ADDR_TIMER_CTRL, 8'hBF);
      for (int i = 0; i < 4; i++) begin
         lf = lfsr(lf);
         wr(TWP_ADDR_WD_CTRL, lf[7:0]);
         rd(TWP_ADDR_WD_CTRL, lf[7:0] & 8'hFC);
         wr(TWP_ADDR_IRQ_MASK, lf[15:8]);
         rd(TWP_ADDR_IRQ_MASK, lf[15:8]);
      end
      wr(8'h30, lf[23:16]);
      rd(8'h30, 8'h00);
      // Internal source: read spacing is four clocks
      wr(TWP_ADDR_WD_CTRL, 8'h00);
      // Prescaler enabled on purpose: the internal source must ignore it
      wr(TWP_ADDR_TIMER_CTRL, 8'h87);
      rdv(TWP_ADDR_TIMER_COUNT, v1);
      rdv(TWP_ADDR_TIMER_COUNT, v2);
      check(8'(v2 - v1), 8'h04);
      wr(TWP_ADDR_IRQ_MASK, 8'h01);
      wr(TWP_ADDR_TIMER_COUNT, 8'hFC);
      repeat (8) @(posedge sys_clk);
      check(timer_irq, 1'b1);
      wr(TWP_ADDR_IRQ_MASK, 8'h00);
      @(posedge sys_clk);
      check(timer_irq, 1'b0);
      pulse(3'b010);
      rdv(TWP_ADDR_TIMER_COUNT, v1);
      rdv(TWP_ADDR_TIMER_COUNT, v2);
      check(8'(v2 - v1), 8'h00);
      wr(TWP_ADDR_MISC_CTRL, 8'h01);
      conversion_busy <= 1'b1;
      rdv(TWP_ADDR_TIMER_COUNT, v1);
      rdv(TWP_ADDR_TIMER_COUNT, v2);
      check(8'(v2 - v1), 8'h04);
      conversion_busy <= 1'b0;
      pulse(3'b100);
      wr(TWP_ADDR_MISC_CTRL, 8'h00);
      // External source: edges, prescaler, count write clearing it
      // Pin starts high for the edge-select pair, so rising and falling counts differ
      for (int i = 0; i < 4; i++) begin
         wr(TWP_ADDR_TIMER_CTRL, tc[i]);
         timer_in_pin <= (i < 2);
         tpin(pre[i]);
         wr(TWP_ADDR_TIMER_COUNT, 8'h00);
         tpin(post[i]);
         rd(TWP_ADDR_TIMER_COUNT, 8'(ex[i]));
      end
      // Watchdog: every ratio code, then 1:1; clear or sleep mid-count
      p = wd_pulses;
      for (int i = 0; i < 9; i++) begin
         n = (i == 8) ? (1 << WDW) : ((1 << WDW) << (i + 1));
         wr(TWP_ADDR_WD_CTRL, (i == 8) ? 8'h80 : (8'hA0 | 8'(i << 2)));
         osc(2);
         pulse(i[0] ? 3'b010 : 3'b001);
         osc(n - 1);
         check(wd_pulses, p);
         osc(1);
         p++;
         check(wd_pulses, p);
      end
      wr(TWP_ADDR_WD_CTRL, 8'h00);
      osc(12);
      check(wd_pulses, p);
      // Port 5 bit 0: plain output, then interrupt input
      wr(TWP_ADDR_PORT5_DIR, 8'h00);
      wr(TWP_ADDR_PORT5_DATA, 8'h01);
      repeat (2) @(posedge sys_clk);
      check({port5_bit0_pin_oe_n, port5_bit0_pin_out}, 2'b01);
      wr(TWP_ADDR_PORT5_DIR, 8'h01);
      wr(TWP_ADDR_WD_CTRL, 8'h40);
      port5_bit0_pin_in <= 1'b0;
      repeat (5) @(posedge sys_clk);
      check({port5_bit0_pin_oe_n, ext_irq_req}, 2'b11);
      rd(TWP_ADDR_PORT5_DATA, 8'h00);
      port5_bit0_pin_in <= 1'b1;
      repeat (5) @(posedge sys_clk);
      check(ext_irq_req, 1'b0);
      rd(TWP_ADDR_PORT5_DATA, 8'h01);
      wr(TWP_ADDR_WD_CTRL, 8'h00);
      port5_bit0_pin_in <= 1'b0;
      repeat (5) @(posedge sys_clk);
      check(ext_irq_req, 1'b0);
      // Mid-run reset restores the watchdog control defaults
      wr(TWP_ADDR_WD_CTRL, 8'h7C);
      reset <= 1'b1;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      rd(TWP_ADDR_WD_CTRL, 8'h80);
      test_done;
   end
endmodule

// ### verif/twp_props.sv
// Checker of bus answers, watchdog pulses and pin events
module twp_props
   import twp_pkg::*;
#(
   parameter int WD_CNT_W = 8,
   parameter int PS_W = 8
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   // Strobes
   input wire logic wd_clear_instruction,
   input wire logic sleep_instruction,
   input wire logic wake_event,
   input wire logic conversion_busy,
   // Pins
   input wire logic wd_osc_pin,
   input wire logic timer_in_pin,
   input wire logic port5_bit0_pin_in,
   input wire logic port5_bit0_pin_out,
   input wire logic port5_bit0_pin_oe_n,
   // Events
   input wire logic wd_reset_req,
   input wire logic ext_irq_req,
   input wire logic timer_irq
);
   timeunit 1ns;
   timeprecision 100ps;
   // ==========================================================
   // Helpers
   logic rd_take;
   logic wr_take;
   logic [3:0] osc_age_r;
   assign rd_take = hready && hsel && htrans[1] && !hwrite;
   assign wr_take = hready && hsel && htrans[1] && hwrite;
   // Cycles since the oscillator pin last rose, saturating
   always_ff @(posedge sys_clk) begin
      if (reset)
         osc_age_r <= 4'hF;
      else if ($rose(wd_osc_pin))
         osc_age_r <= 4'h0;
      else if (osc_age_r != 4'hF)
         osc_age_r <= osc_age_r + 4'h1;
   end
   // ==========================================================
   // Properties
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("hresp not okay");
   a_read_wait: assert property (rd_take |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   a_write_nowait: assert property (wr_take |=> hreadyout)
      else $error("write stalled");
   a_wd_single: assert property (wd_reset_req |=> !wd_reset_req)
      else $error("watchdog pulse too long");
   a_wd_osc_tick: assert property (wd_reset_req |-> osc_age_r <= 4'h8)
      else $error("time-out without oscillator tick");
   a_clear_blocks: assert property ((wd_clear_instruction || sleep_instruction) |=> !wd_reset_req [*2])
      else $error("time-out right after clear");
   a_ext_irq_sel: assert property (ext_irq_req |-> port5_bit0_pin_oe_n && !$past(port5_bit0_pin_in, 2))
      else $error("interrupt request while pin driven");
   a_irq_sticky: assert property ($fell(timer_irq) |-> $past(wr_take, 2))
      else $error("timer interrupt dropped without write");
   a_reset_quiet: assert property (disable iff (1'b0)
      reset |=> !wd_reset_req && !timer_irq && !ext_irq_req && port5_bit0_pin_oe_n)
      else $error("events active after reset");
   c_read: cover property (rd_take);
   c_wd: cover property ($rose(wd_reset_req));
   c_ext: cover property ($rose(ext_irq_req));
   c_tim: cover property ($rose(timer_irq));
endmodule

bind twp_timer_watchdog twp_props #(.WD_CNT_W(WD_CNT_W), .PS_W(PS_W)) u_twp_props (
   .sys_clk(sys_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .wd_clear_instruction(wd_clear_instruction), .sleep_instruction(sleep_instruction),
   .wake_event(wake_event), .conversion_busy(conversion_busy), .wd_osc_pin(wd_osc_pin),
   .timer_in_pin(timer_in_pin), .port5_bit0_pin_in(port5_bit0_pin_in),
   .port5_bit0_pin_out(port5_bit0_pin_out), .port5_bit0_pin_oe_n(port5_bit0_pin_oe_n),
   .wd_reset_req(wd_reset_req), .ext_irq_req(ext_irq_req), .timer_irq(timer_irq));
